// >>> flash_host_consts.svh
// constants for the parallel flash host controller
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define RESET_LOW_MIN_NS 500
`define RESET_RELEASE_TO_READ_NS 200
`define TOGGLE_STROBE_HIGH_MIN_NS 150
`define WRITE_PULSE_MIN_NS 50
`define WRITE_HIGH_MIN_NS 40
`define READ_ACCESS_NS 110
`define SUSPEND_LATENCY_US 15
`define PROGRAM_MAX_US 50
`define SECTOR_ERASE_MAX_MS 400
`define CHIP_ERASE_MAX_S 10
`define CMD_ADDR_UNLOCK1 12'h0555
`define CMD_ADDR_UNLOCK2 12'h0AAA
`define CMD_DATA_UNLOCK1 8'hAA
`define CMD_DATA_UNLOCK2 8'h55
`define CMD_DATA_PROGRAM 8'hA0
`define CMD_DATA_ERASE_SETUP 8'h80
`define CMD_DATA_CHIP_ERASE 8'h10
`define CMD_DATA_SECTOR_ERASE 8'h30
`define CMD_DATA_SUSPEND 8'hB0
`define CMD_DATA_RESUME 8'hD0
`define CMD_DATA_ID_ENTRY 8'h90
`define CMD_DATA_ID_EXIT 8'hF0
`define POLARITY_BIT 7
`define TOGGLE_BIT 6
`define ERASE_TOGGLE_BIT 2
`endif

// >>> flash_host_pkg.sv
// types for the parallel flash host controller
`default_nettype none
package flash_host_pkg;
   typedef enum logic [2:0] {
      OP_READ = 3'd0,
      OP_PROGRAM = 3'd1,
      OP_SECTOR_ERASE = 3'd2,
      OP_CHIP_ERASE = 3'd3,
      OP_SUSPEND = 3'd4,
      OP_RESUME = 3'd5,
      OP_ID_ENTRY = 3'd6,
      OP_ID_EXIT = 3'd7
   } op_t;
   typedef enum logic [3:0] {
      ST_RESET = 4'b0000,
      ST_RECOVER = 4'b0001,
      ST_IDLE = 4'b0011,
      ST_WR_LOW = 4'b0010,
      ST_WR_HIGH = 4'b0110,
      ST_RD_LOW = 4'b0111,
      ST_RD_HIGH = 4'b0101,
      ST_DONE = 4'b0100
   } state_t;
endpackage
`default_nettype wire

// >>> flash_host.sv
// host controller driving the parallel flash through its pins
`include "flash_host_consts.svh"
`default_nettype none
module flash_host #(
   parameter int ADDR_W = 21,
   parameter int unsigned SUSPEND_CYC =
      (`SUSPEND_LATENCY_US * 1000) / `CLK_PERIOD_NS,
   parameter int unsigned PROGRAM_CYC =
      (`PROGRAM_MAX_US * 1000) / `CLK_PERIOD_NS,
   parameter int unsigned SECTOR_CYC =
      (`SECTOR_ERASE_MAX_MS * 100000) / `CLK_PERIOD_NS * 10,
   parameter int unsigned CHIP_CYC = 32'd1_000_000_000
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic req_in,
   input wire flash_host_pkg::op_t op_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [15:0] wdata_in,
   output logic ready_out,
   output logic done_out,
   output logic timeout_out,
   output logic [15:0] rdata_out,
   output logic [ADDR_W-1:0] flash_addr_out,
   output logic flash_cen_out,
   output logic flash_oen_out,
   output logic flash_wen_out,
   output logic flash_resetn_out,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe_out,
   input wire logic [15:0] flash_dq_in
);
   import flash_host_pkg::*;

   // ----------------------------------------
   // timing counts
   // ----------------------------------------
   localparam int RST_CYC =
      (`RESET_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int REC_CYC =
      (`RESET_RELEASE_TO_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int TGH_CYC =
      (`TOGGLE_STROBE_HIGH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int WPL_CYC =
      (`WRITE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int WPH_CYC =
      (`WRITE_HIGH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int RDL_CYC =
      (`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1;

   // ----------------------------------------
   // state
   // ----------------------------------------
   state_t state, next_state;
   op_t op, next_op;
   logic [31:0] cnt, next_cnt;
   logic [31:0] wait_cnt, next_wait_cnt;
   logic [2:0] step, next_step;
   logic [2:0] nsteps, next_nsteps;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [15:0] wdata, next_wdata;
   logic [15:0] rdata, next_rdata;
   logic [15:0] last, next_last;
   logic polling, next_polling;
   logic have_last, next_have_last;
   logic done, next_done;
   logic timeout, next_timeout;
   logic [ADDR_W-1:0] cyc_addr;
   logic [7:0] cyc_data;

   function automatic logic [ADDR_W-1:0] cmd_addr(input logic [11:0] a);
      cmd_addr = {{(ADDR_W-12){1'b0}}, a};
   endfunction

   // one bus write of the command sequence for the current op and step
   always_comb begin
      cyc_addr = cmd_addr(`CMD_ADDR_UNLOCK1);
      cyc_data = `CMD_DATA_UNLOCK1;
      if (step == 3'd1) begin
         cyc_addr = cmd_addr(`CMD_ADDR_UNLOCK2);
         cyc_data = `CMD_DATA_UNLOCK2;
      end else if (step == 3'd4) begin
         cyc_addr = cmd_addr(`CMD_ADDR_UNLOCK2);
         cyc_data = `CMD_DATA_UNLOCK2;
      end else if (step == 3'd3) begin
         cyc_data = `CMD_DATA_UNLOCK1;
      end else if (step == 3'd2) begin
         case (op)
            OP_PROGRAM: cyc_data = `CMD_DATA_PROGRAM;
            OP_ID_ENTRY: cyc_data = `CMD_DATA_ID_ENTRY;
            OP_ID_EXIT: cyc_data = `CMD_DATA_ID_EXIT;
            default: cyc_data = `CMD_DATA_ERASE_SETUP;
         endcase
      end else if (step == 3'd5) begin
         if (op == OP_CHIP_ERASE) begin
            cyc_data = `CMD_DATA_CHIP_ERASE;
         end else begin
            cyc_addr = addr;
            cyc_data = `CMD_DATA_SECTOR_ERASE;
         end
      end
      if (op == OP_SUSPEND || op == OP_RESUME) begin
         cyc_addr = addr;
         cyc_data = (op == OP_SUSPEND) ? `CMD_DATA_SUSPEND
                                       : `CMD_DATA_RESUME;
      end
   end

   always_comb begin
      next_state = state;
      next_op = op;
      next_cnt = cnt;
      next_wait_cnt = wait_cnt;
      next_step = step;
      next_nsteps = nsteps;
      next_addr = addr;
      next_wdata = wdata;
      next_rdata = rdata;
      next_last = last;
      next_polling = polling;
      next_have_last = have_last;
      next_done = 1'b0;
      next_timeout = 1'b0;
      case (state)
         ST_RESET: begin
            next_cnt = cnt + 32'd1;
            if (cnt >= 32'(RST_CYC - 1)) begin
               next_cnt = '0;
               next_state = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            next_cnt = cnt + 32'd1;
            if (cnt >= 32'(REC_CYC - 1)) begin
               next_cnt = '0;
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (req_in) begin
               next_op = op_in;
               next_addr = addr_in;
               next_wdata = wdata_in;
               next_step = 3'd0;
               next_cnt = '0;
               next_wait_cnt = '0;
               next_polling = 1'b0;
               next_have_last = 1'b0;
               case (op_in)
                  OP_READ: next_state = ST_RD_LOW;
                  OP_PROGRAM: next_nsteps = 3'd4;
                  OP_SECTOR_ERASE: next_nsteps = 3'd6;
                  OP_CHIP_ERASE: next_nsteps = 3'd6;
                  OP_SUSPEND: next_nsteps = 3'd1;
                  OP_RESUME: next_nsteps = 3'd1;
                  default: next_nsteps = 3'd3;
               endcase
               if (op_in != OP_READ) begin
                  next_state = ST_WR_LOW;
               end
            end
         end
         ST_WR_LOW: begin
            next_cnt = cnt + 32'd1;
            if (cnt >= 32'(WPL_CYC - 1)) begin
               next_cnt = '0;
               next_state = ST_WR_HIGH;
            end
         end
         ST_WR_HIGH: begin
            next_cnt = cnt + 32'd1;
            if (cnt >= 32'(WPH_CYC - 1)) begin
               next_cnt = '0;
               next_step = step + 3'd1;
               if (op == OP_PROGRAM && step == 3'd3) begin
                  next_state = ST_RD_HIGH;
                  next_polling = 1'b1;
               end else if (step + 3'd1 < nsteps) begin
                  next_state = ST_WR_LOW;
               end else if (op == OP_SECTOR_ERASE ||
                            op == OP_CHIP_ERASE) begin
                  next_state = ST_RD_HIGH;
                  next_polling = 1'b1;
               end else if (op == OP_SUSPEND) begin
                  next_wait_cnt = wait_cnt + 32'd1;
                  next_state = ST_WR_HIGH;
                  next_step = step;
                  next_cnt = cnt;
                  if (wait_cnt >= SUSPEND_CYC) begin
                     next_state = ST_DONE;
                  end
               end else begin
                  next_state = ST_DONE;
               end
            end
         end
         ST_RD_LOW: begin
            next_cnt = cnt + 32'd1;
            if (polling) begin
               next_wait_cnt = wait_cnt + 32'd1;
            end
            if (cnt >= 32'(RDL_CYC - 1)) begin
               next_cnt = '0;
               next_rdata = flash_dq_in;
               if (!polling) begin
                  next_state = ST_DONE;
               end else begin
                  next_last = flash_dq_in;
                  next_have_last = 1'b1;
                  next_state = ST_RD_HIGH;
                  if (have_last &&
                      flash_dq_in[`TOGGLE_BIT] == last[`TOGGLE_BIT]) begin
                     next_state = ST_DONE;
                  end
               end
            end
         end
         ST_RD_HIGH: begin
            next_cnt = cnt + 32'd1;
            next_wait_cnt = wait_cnt + 32'd1;
            if (cnt >= 32'(TGH_CYC - 1)) begin
               next_cnt = '0;
               next_state = ST_RD_LOW;
            end
            if ((op == OP_PROGRAM && wait_cnt >= PROGRAM_CYC) ||
                (op == OP_SECTOR_ERASE && wait_cnt >= SECTOR_CYC) ||
                (op == OP_CHIP_ERASE && wait_cnt >= CHIP_CYC)) begin
               next_timeout = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_done = 1'b1;
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= ST_RESET;
         op <= OP_READ;
         cnt <= '0;
         wait_cnt <= '0;
         step <= '0;
         nsteps <= '0;
         addr <= '0;
         wdata <= '0;
         rdata <= '0;
         last <= '0;
         polling <= 1'b0;
         have_last <= 1'b0;
         done <= 1'b0;
         timeout <= 1'b0;
      end else begin
         state <= next_state;
         op <= next_op;
         cnt <= next_cnt;
         wait_cnt <= next_wait_cnt;
         step <= next_step;
         nsteps <= next_nsteps;
         addr <= next_addr;
         wdata <= next_wdata;
         rdata <= next_rdata;
         last <= next_last;
         polling <= next_polling;
         have_last <= next_have_last;
         done <= next_done;
         timeout <= next_timeout;
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------
   logic prog_data;
   assign prog_data = (op == OP_PROGRAM) && (step == 3'd3);
   assign ready_out = (state == ST_IDLE);
   assign done_out = done;
   assign timeout_out = timeout;
   assign rdata_out = rdata;
   assign flash_resetn_out = (state != ST_RESET);
   // polling reads stay on the target address
   assign flash_addr_out = (state == ST_RD_LOW || state == ST_RD_HIGH ||
                            prog_data) ? addr : cyc_addr;
   assign flash_cen_out = !(state == ST_WR_LOW || state == ST_RD_LOW);
   assign flash_wen_out = !(state == ST_WR_LOW);
   assign flash_oen_out = !(state == ST_RD_LOW);
   assign flash_dq_oe_out = (state == ST_WR_LOW || state == ST_WR_HIGH);
   assign flash_dq_out = prog_data ? wdata : {8'h00, cyc_data};
endmodule
`default_nettype wire

// >>> flash_host_chk.sv
// pin-level checker for the flash host controller
`default_nettype none
module flash_host_chk #(
   parameter int ADDR_W = 21
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic ready_out,
   input wire logic [ADDR_W-1:0] flash_addr_out,
   input wire logic flash_oen_out,
   input wire logic flash_wen_out,
   input wire logic flash_resetn_out,
   input wire logic [15:0] flash_dq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   logic [7:0] low_n, up_n, oeh_n;
   logic poll, seen, arm;
   logic [ADDR_W-1:0] poll_a;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         {low_n, up_n, oeh_n} <= 24'h00_0000;
         {poll, seen, arm} <= 3'h0;
         poll_a <= '0;
      end else begin
         low_n <= flash_resetn_out ? 8'h00 : low_n + 8'h01;
         up_n <= !flash_resetn_out ? 8'h00 : up_n + {7'h00, up_n != 8'hff};
         oeh_n <= !flash_oen_out ? 8'h00 : oeh_n + {7'h00, oeh_n != 8'hff};
         poll <= !ready_out && (poll || !flash_wen_out);
         arm <= !ready_out && (arm || (!flash_wen_out &&
            flash_dq_out[7:0] == 8'h80));
         if (ready_out) seen <= 1'b0;
         else if (poll && $fell(flash_oen_out)) begin
            seen <= 1'b1;
            poll_a <= flash_addr_out;
         end
      end
   end
   sequence wr_low_s;
      !flash_wen_out [*5];
   endsequence
   sequence poll_rd_s;
      poll && $fell(flash_oen_out);
   endsequence
   reset_hold_a:
      assert property ($rose(flash_resetn_out) |-> low_n >= 8'h32)
      else $error("device reset pulse too short");
   read_gap_a:
      assert property ($fell(flash_oen_out) |-> up_n >= 8'h14)
      else $error("read too soon after reset");
   poll_pulse_a:
      assert property (poll_rd_s |-> oeh_n >= 8'h0f)
      else $error("poll strobe high too short");
   poll_addr_a:
      assert property (poll && seen && $fell(flash_oen_out) |->
      flash_addr_out == poll_a) else $error("poll address moved");
   chip_erase_a:
      assert property (arm && $fell(flash_wen_out) &&
      flash_dq_out[7:0] == 8'h10 |-> flash_addr_out[11:0] == 12'h555)
      else $error("chip erase address wrong");
   write_pulse_a:
      assert property ($fell(flash_wen_out) |-> wr_low_s)
      else $error("write strobe too short");
endmodule
bind flash_host flash_host_chk #(.ADDR_W(ADDR_W)) chk (.clk_in(clk_in),
   .rstn_in(rstn_in), .ready_out(ready_out), .flash_addr_out(flash_addr_out),
   .flash_oen_out(flash_oen_out), .flash_wen_out(flash_wen_out),
   .flash_resetn_out(flash_resetn_out), .flash_dq_out(flash_dq_out));
`default_nettype wire

// >>> flash_dev_model.sv
// behavioural flash device answering the host pins
`default_nettype none
module flash_dev_model #(
   parameter logic [15:0] ID0 = 16'h0000,
   parameter logic [15:0] ID1 = 16'h0000,
   parameter logic [15:0] ID3 = 16'h0000,
   parameter int BUSY = 5
) (
   input wire logic [20:0] a_in,
   input wire logic cen_in,
   input wire logic oen_in,
   input wire logic wen_in,
   input wire logic resetn_in,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [16];
   logic [15:0] word, tgt, last = 16'h0000;
   logic [7:0] c;
   logic pgm = 1'b0, arm = 1'b0, id = 1'b0, ers = 1'b0, tog = 1'b0;
   logic susp = 1'b0;
   logic [3:0] esec = 4'h0;
   int busy = 0;
   int held = 0;
   initial foreach (mem[i]) mem[i] = 16'h0000;
   always @(negedge resetn_in) begin
      busy = 0;
      {pgm, arm, id} = 3'h0;
      susp = 1'b0;
   end
   always @(posedge wen_in) begin
      c = dq_in[7:0];
      if (pgm) begin
         mem[a_in[3:0]] = dq_in;
         tgt = dq_in;
         {pgm, ers} = 2'b00;
         busy = BUSY;
      end else if (c == 8'ha0) pgm = 1'b1;
      else if (c == 8'h80) arm = 1'b1;
      else if (arm && (c == 8'h10 || c == 8'h30)) begin
         esec = a_in[3:0];
         if (c == 8'h10 && a_in[11:0] == 12'h555)
            foreach (mem[i]) mem[i] = 16'hffff;
         else
            mem[a_in[3:0]] = 16'hffff;
         {arm, ers} = 2'b01;
         busy = BUSY;
      end else if (c == 8'h90) id = 1'b1;
      else if (c == 8'hf0) id = 1'b0;
      // suspend halts an erase at once
      else if (c == 8'hb0) begin
         susp = ers && busy > 0;
         held = busy;
         busy = 0;
      end else if (c == 8'hd0 && susp) begin
         busy = held;
         ers = 1'b1;
         susp = 1'b0;
      end
   end
   always @(negedge oen_in) begin
      if (busy > 0) begin
         tog = ~tog;
         busy--;
      end else if (susp) begin
         tog = ~tog;
      end
   end
   always_comb begin
      word = mem[a_in[3:0]];
      if (id) word = a_in[1:0] == 2'h0 ? ID0 : a_in[1] ? ID3 : ID1;
      if (busy > 0) begin
         word[7] = ers ? 1'b0 : ~tgt[7];
         word[6] = tog;
         word[2] = (ers || susp) ? tog : 1'b1;
      end else if (susp && a_in[3:0] == esec) begin
         word[7] = 1'b1;
         word[6] = 1'b1;
         word[2] = tog;
      end
   end
   always @(posedge oen_in) if (resetn_in === 1'b1) last = word;
   // a released bus shows the inverse of the last word
   assign dq_out = (!cen_in && !oen_in) ? word : ~last;
endmodule
`default_nettype wire

// >>> flash_host_tb.sv
// self-checking bench for the flash host controller
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module flash_host_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_host_pkg::*;
   // arbitrary identification codes
   localparam logic [15:0] MK = 16'h0a5c, DV = 16'h0b6d, DV3 = 16'h0c7e;
   typedef struct {op_t op; logic [20:0] a; logic [15:0] d;} row_t;
   row_t rows [17] = '{
      '{OP_PROGRAM, 21'h1, 16'h1234}, '{OP_READ, 21'h1, 16'h1234},
      '{OP_PROGRAM, 21'h2, 16'h00c3}, '{OP_READ, 21'h2, 16'h00c3},
      '{OP_ID_ENTRY, 21'h0, 16'h0000}, '{OP_READ, 21'h0, MK},
      '{OP_READ, 21'h1, DV}, '{OP_READ, 21'h3, DV3},
      '{OP_ID_EXIT, 21'h0, 16'h0000}, '{OP_READ, 21'h1, 16'h1234},
      '{OP_SECTOR_ERASE, 21'h2, 16'h0000}, '{OP_READ, 21'h2, 16'hffff},
      '{OP_READ, 21'h1, 16'h1234}, '{OP_SUSPEND, 21'h1, 16'h0000},
      '{OP_RESUME, 21'h1, 16'h0000}, '{OP_CHIP_ERASE, 21'h0, 16'h0000},
      '{OP_READ, 21'h1, 16'hffff}};
   logic clk_in = 1'b0, rstn_in = 1'b0, req_in = 1'b0;
   op_t op_in = OP_READ;
   logic [20:0] addr_in = 21'h0, fa;
   logic [15:0] wdata_in = 16'h0000, rdata_out, dq_o, dev_q, bus;
   logic ready_out, done_out, timeout_out, cen, oen, wen, rsn, oe;
   int errors = 0, checks = 0, n;
   always #5 clk_in = ~clk_in;
   assign bus = oe ? dq_o : dev_q;
   flash_host #(.PROGRAM_CYC(2000), .SECTOR_CYC(2000), .CHIP_CYC(2000),
      .SUSPEND_CYC(50)) DUT (.clk_in(clk_in), .rstn_in(rstn_in),
      .req_in(req_in), .op_in(op_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .ready_out(ready_out), .done_out(done_out),
      .timeout_out(timeout_out), .rdata_out(rdata_out),
      .flash_addr_out(fa), .flash_cen_out(cen), .flash_oen_out(oen),
      .flash_wen_out(wen), .flash_resetn_out(rsn), .flash_dq_out(dq_o),
      .flash_dq_oe_out(oe), .flash_dq_in(bus));
   flash_dev_model #(.ID0(MK), .ID1(DV), .ID3(DV3)) mdl (.a_in(fa),
      .cen_in(cen), .oen_in(oen), .wen_in(wen), .resetn_in(rsn),
      .dq_in(bus), .dq_out(dev_q));
   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic run(input op_t op, input logic [20:0] a,
         input logic [15:0] d);
      @(posedge clk_in);
      req_in <= 1'b1;
      op_in <= op;
      addr_in <= a;
      wdata_in <= d;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (ready_out !== 1'b1 && n < 5000);
      // request is taken at this edge
      @(posedge clk_in);
      req_in <= 1'b0;
      do begin
         @(negedge clk_in);
         n++;
      end while (done_out !== 1'b1 && timeout_out !== 1'b1 && n < 9000);
      `CHK(done_out, 1'b1)
      `CHK(timeout_out, 1'b0)
      if (n >= 9000) conclude();
   endtask
   initial begin
      repeat (16) @(posedge clk_in);
      rstn_in <= 1'b1;
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].a, rows[i].d);
         if (rows[i].op == OP_READ)
            `CHK(rdata_out, rows[i].d)
         $display("test %0d ended", i);
      end
      @(posedge clk_in);
      req_in <= 1'b1;
      op_in <= OP_PROGRAM;
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b0;
      req_in <= 1'b0;
      @(negedge clk_in);
      `CHK({rsn, ready_out}, 2'b00)
      @(posedge clk_in);
      rstn_in <= 1'b1;
      op_in <= OP_READ;
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (ready_out !== 1'b1 && n < 200);
      `CHK(ready_out, 1'b1)
      `CHK(n > 69, 1'b1)
      run(OP_READ, 21'h1, 16'h0000);
      `CHK(rdata_out, 16'hffff)
      $display("test reset ended");
      conclude();
   end
endmodule
`default_nettype wire
